// *** front_end_control_pkg.sv ***
// Constants shared by the front-end control and dither register block.
// Assumes a 200 MHz device clock and an AXI4-Lite register port with 32-bit data.
//
// What this block does
// RULE1: Effective phase threshold equals register times four.
// RULE2: Calibration bit routes all channels to reference.
// RULE3: Clamp and servo pause while coasting unless enabled.
// RULE4: Set midscale bit adds half-scale channel shift.
// RULE5: Override clear: midscale follows colour-format mode.
// RULE6: Colour-format mode set means component colour-difference.
// RULE7: Dither injected only while enable bit set.
// RULE8: Amplitude bit selects sixteen or eight LSBs.
// RULE9: Increment code picks pixel, hsync or vsync.
// RULE10: Software pulses seed-reset bit to restart sequence.
// RULE11: Pixel PLL offers sixty-four sampling phases.
// RULE12: Pixel clock derived from crystal, drift free.
// RULE13: Only pixels per line programmed; loop self-locks.
// RULE14: Dither comes from seeded LFSR, scaled.
package front_end_control_pkg;

  // -------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // -------------------------------------------------------------------
  localparam logic [7:0] IDX_THRESHOLD   = 8'h56;
  localparam logic [7:0] IDX_RESULT3     = 8'h57;
  localparam logic [7:0] IDX_RESULT2     = 8'h58;
  localparam logic [7:0] IDX_RESULT1     = 8'h59;
  localparam logic [7:0] IDX_RESULT0     = 8'h5A;
  localparam logic [7:0] IDX_FRONT_END   = 8'h60;
  localparam logic [7:0] IDX_NOISE       = 8'h61;
  localparam logic [7:0] IDX_LINE_PIXELS = 8'h62;
  localparam logic [7:0] IDX_PHASE_SEL   = 8'h63;
  localparam logic [7:0] IDX_STATUS      = 8'h64;

  // -------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------
  localparam logic [7:0]  RST_THRESHOLD   = 8'h0A;
  localparam logic [7:0]  RST_FRONT_END   = 8'h00;
  localparam logic [7:0]  RST_NOISE       = 8'h00;
  localparam logic [11:0] RST_LINE_PIXELS = 12'h698;
  localparam logic [5:0]  RST_PHASE_SEL   = 6'h00;

  // -------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------
  localparam int FE_CAL      = 1;
  localparam int FE_COAST    = 2;
  localparam int FE_MID_LO   = 4;
  localparam int FE_OVERRIDE = 7;
  localparam int NC_ENABLE   = 0;
  localparam int NC_AMPL     = 1;
  localparam int NC_INC_LO   = 2;
  localparam int NC_SEED     = 4;
  localparam logic [7:0] FE_WMASK = 8'hF6;
  localparam logic [7:0] NC_WMASK = 8'h1F;

  // -------------------------------------------------------------------
  // Dither increment codes and pixel loop figures
  // -------------------------------------------------------------------
  localparam logic [1:0]  INC_PIXEL = 2'h0;
  localparam logic [1:0]  INC_HSYNC = 2'h1;
  localparam int          CLK_MHZ   = 200;
  localparam int          PIX_MIN_MHZ = 10;
  localparam int          PIX_MAX_MHZ = 165;
  // Phase increment per clock is pixel rate over clock rate times two to the 32nd.
  localparam logic [31:0] NCO_MIN_INC = 32'((64'(PIX_MIN_MHZ) << 32) / CLK_MHZ);
  localparam logic [31:0] NCO_MAX_INC = 32'((64'(PIX_MAX_MHZ) << 32) / CLK_MHZ);
  localparam logic [31:0] NCO_STEP    = 32'h0001_0000;
  localparam logic [3:0]  LOCK_LINES  = 4'h8;
  localparam logic [15:0] LFSR_SEED   = 16'hACE1;

endpackage

// *** front_end_control_dither_regs.sv ***
// Front-end control, dither generator and pixel loop with an AXI4-Lite register port.
// Assumes hsync and vsync arrive as single-cycle pulses synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

module front_end_control_dither_regs
#(
  parameter int PPL_W = 12
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        hsync_pulse,
  input  wire logic        vsync_pulse,
  input  wire logic        pll_coasting,
  input  wire logic        protect_interval,
  input  wire logic        ycbcr_mode,
  input  wire logic [31:0] phase_result,
  output var  logic [9:0]  threshold_word,
  output var  logic        reference_calibration_select,
  output var  logic        dc_clamp_run,
  output var  logic        black_level_servo_run,
  output var  logic [2:0]  midscale_shift,
  output var  logic [3:0]  dither_offset,
  output var  logic        pixel_tick,
  output var  logic        sample_strobe,
  output var  logic        pll_locked
);

  // -------------------------------------------------------------------
  // Register storage
  // -------------------------------------------------------------------
  logic [7:0]       threshold_r;
  logic [7:0]       front_end_r;
  logic [7:0]       noise_r;
  logic [PPL_W-1:0] line_pixels_r;
  logic [5:0]       phase_sel_r;

  logic             aw_held_r;
  logic             w_held_r;
  logic [7:0]       aw_idx_r;
  logic             aw_bad_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             wr_fire;

  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic addr_unmapped(input logic [31:0] addr);
    logic [7:0] i;
    i = addr[9:2];
    addr_unmapped = (addr[31:10] != 22'h0) || (addr[1:0] != 2'h0) ||
                    !((i >= front_end_control_pkg::IDX_THRESHOLD && i <= front_end_control_pkg::IDX_RESULT0) ||
                      (i >= front_end_control_pkg::IDX_FRONT_END && i <= front_end_control_pkg::IDX_STATUS));
  endfunction

  // -------------------------------------------------------------------
  // AXI4-Lite write path
  // -------------------------------------------------------------------
  // Address and data are parked independently; the write commits once both are held
  // and no response is pending, so either may arrive first.
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r     <= 1'b0;
      aw_idx_r      <= 8'h00;
      aw_bad_r      <= 1'b0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r     <= 1'b1;
      aw_idx_r      <= word_index(s_axi_awaddr);
      aw_bad_r      <= addr_unmapped(s_axi_awaddr);
      s_axi_awready <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_held_r     <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !s_axi_awready ? 1'b1 : s_axi_awready;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r     <= 1'b0;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r     <= 1'b1;
      wdata_r      <= s_axi_wdata;
      wstrb_r      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (wr_fire)
    begin
      w_held_r     <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_held_r && !s_axi_wready ? 1'b1 : s_axi_wready;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_bad_r ? 2'h2 : 2'h0;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries register bits, except the wider line-pixel count.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      threshold_r   <= front_end_control_pkg::RST_THRESHOLD;
      front_end_r   <= front_end_control_pkg::RST_FRONT_END;
      noise_r       <= front_end_control_pkg::RST_NOISE;
      line_pixels_r <= PPL_W'(front_end_control_pkg::RST_LINE_PIXELS);
      phase_sel_r   <= front_end_control_pkg::RST_PHASE_SEL;
    end
    else if (wr_fire && !aw_bad_r)
    begin
      if (wstrb_r[0] && aw_idx_r == front_end_control_pkg::IDX_THRESHOLD)
        threshold_r <= wdata_r[7:0];
      if (wstrb_r[0] && aw_idx_r == front_end_control_pkg::IDX_FRONT_END)
        front_end_r <= wdata_r[7:0] & front_end_control_pkg::FE_WMASK;
      if (wstrb_r[0] && aw_idx_r == front_end_control_pkg::IDX_NOISE)
        noise_r <= wdata_r[7:0] & front_end_control_pkg::NC_WMASK;
      if (wstrb_r[0] && aw_idx_r == front_end_control_pkg::IDX_PHASE_SEL)
        phase_sel_r <= wdata_r[5:0];
      if (wstrb_r[1:0] == 2'h3 && aw_idx_r == front_end_control_pkg::IDX_LINE_PIXELS)
        line_pixels_r <= wdata_r[PPL_W-1:0]; // RULE13
    end
  end

  // -------------------------------------------------------------------
  // AXI4-Lite read path
  // -------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= addr_unmapped(s_axi_araddr) ? 2'h2 : 2'h0;
      unique case (word_index(s_axi_araddr))
        front_end_control_pkg::IDX_THRESHOLD:   s_axi_rdata <= {24'h0, threshold_r};
        front_end_control_pkg::IDX_RESULT3:     s_axi_rdata <= {24'h0, phase_result[31:24]};
        front_end_control_pkg::IDX_RESULT2:     s_axi_rdata <= {24'h0, phase_result[23:16]};
        front_end_control_pkg::IDX_RESULT1:     s_axi_rdata <= {24'h0, phase_result[15:8]};
        front_end_control_pkg::IDX_RESULT0:     s_axi_rdata <= {24'h0, phase_result[7:0]};
        front_end_control_pkg::IDX_FRONT_END:   s_axi_rdata <= {24'h0, front_end_r};
        front_end_control_pkg::IDX_NOISE:       s_axi_rdata <= {24'h0, noise_r};
        front_end_control_pkg::IDX_LINE_PIXELS: s_axi_rdata <= 32'(line_pixels_r);
        front_end_control_pkg::IDX_PHASE_SEL:   s_axi_rdata <= {26'h0, phase_sel_r};
        front_end_control_pkg::IDX_STATUS:      s_axi_rdata <= {27'h0, pll_locked, dither_offset};
        default:                       s_axi_rdata <= 32'h0000_0000;
      endcase
      if (addr_unmapped(s_axi_araddr))
        s_axi_rdata <= 32'h0000_0000;
    end
    else if (s_axi_rvalid)
    begin
      s_axi_rvalid  <= !s_axi_rready;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // Front-end controls
  // -------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      threshold_word               <= 10'h000;
      reference_calibration_select <= 1'b0;
      dc_clamp_run                 <= 1'b0;
      black_level_servo_run        <= 1'b0;
      midscale_shift               <= 3'h0;
    end
    else
    begin
      threshold_word               <= {threshold_r, 2'h0}; // RULE1
      reference_calibration_select <= front_end_r[front_end_control_pkg::FE_CAL]; // RULE2
      // Pausing avoids clamp errors from equalising pulses while the loop free-runs.
      dc_clamp_run          <= front_end_r[front_end_control_pkg::FE_COAST] || !(pll_coasting || protect_interval); // RULE3
      black_level_servo_run <= front_end_r[front_end_control_pkg::FE_COAST] || !(pll_coasting || protect_interval); // RULE3
      if (front_end_r[front_end_control_pkg::FE_OVERRIDE])
        midscale_shift <= front_end_r[front_end_control_pkg::FE_MID_LO +: 3]; // RULE4 RULE5
      else
        midscale_shift <= ycbcr_mode ? 3'h5 : 3'h0; // RULE5 RULE6
    end
  end

  // -------------------------------------------------------------------
  // Dither generator
  // -------------------------------------------------------------------
  logic [15:0] lfsr_r;
  logic        dither_step;

  always_comb
  begin
    unique case (noise_r[front_end_control_pkg::NC_INC_LO +: 2])
      front_end_control_pkg::INC_PIXEL: dither_step = pixel_tick;
      front_end_control_pkg::INC_HSYNC: dither_step = hsync_pulse;
      default:                 dither_step = vsync_pulse;
    endcase // RULE9
  end

  // The seed bit holds the generator at its seed, so the sequence restarts on release.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lfsr_r <= front_end_control_pkg::LFSR_SEED;
    else if (noise_r[front_end_control_pkg::NC_SEED])
      lfsr_r <= front_end_control_pkg::LFSR_SEED; // RULE10
    else if (dither_step)
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]}; // RULE14
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dither_offset <= 4'h0;
    else if (!noise_r[front_end_control_pkg::NC_ENABLE])
      dither_offset <= 4'h0; // RULE7
    else if (noise_r[front_end_control_pkg::NC_AMPL])
      dither_offset <= {1'b0, lfsr_r[2:0]}; // RULE8 RULE14
    else
      dither_offset <= lfsr_r[3:0]; // RULE8
  end

  // -------------------------------------------------------------------
  // Pixel loop
  // -------------------------------------------------------------------
  // The oscillator accumulates on the crystal-derived clock, so its rate cannot drift
  // within a line; only the line-end correction changes it.
  logic [31:0]      nco_acc_r;
  logic [31:0]      nco_inc_r;
  logic [31:0]      nco_next;
  logic [31:0]      phase_off;
  logic [PPL_W:0]   pix_count_r;
  logic [3:0]       lock_count_r;

  assign nco_next  = nco_acc_r + nco_inc_r;
  assign phase_off = {phase_sel_r, 26'h0};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nco_acc_r     <= 32'h0000_0000;
      pixel_tick    <= 1'b0;
      sample_strobe <= 1'b0;
    end
    else
    begin
      nco_acc_r     <= nco_next; // RULE12
      pixel_tick    <= nco_next < nco_acc_r;
      sample_strobe <= (nco_next - phase_off) < (nco_acc_r - phase_off); // RULE11
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nco_inc_r    <= front_end_control_pkg::NCO_MIN_INC;
      pix_count_r  <= '0;
      lock_count_r <= 4'h0;
      pll_locked   <= 1'b0;
    end
    else if (hsync_pulse)
    begin
      pix_count_r <= '0;
      if (pix_count_r == {1'b0, line_pixels_r})
      begin
        lock_count_r <= (lock_count_r == front_end_control_pkg::LOCK_LINES) ? lock_count_r : lock_count_r + 4'h1;
        pll_locked   <= lock_count_r == front_end_control_pkg::LOCK_LINES;
      end
      else
      begin
        lock_count_r <= 4'h0;
        pll_locked   <= 1'b0;
        if (pix_count_r < {1'b0, line_pixels_r} && nco_inc_r < front_end_control_pkg::NCO_MAX_INC)
          nco_inc_r <= nco_inc_r + front_end_control_pkg::NCO_STEP; // RULE13
        else if (pix_count_r > {1'b0, line_pixels_r} && nco_inc_r > front_end_control_pkg::NCO_MIN_INC)
          nco_inc_r <= nco_inc_r - front_end_control_pkg::NCO_STEP; // RULE13
      end
    end
    else if (pixel_tick && !(&pix_count_r))
    begin
      pix_count_r <= pix_count_r + 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  sequence s_wr_done;
    wr_fire ##1 s_axi_bvalid;
  endsequence

  a_threshold_times_four: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
    aresetn |=> threshold_word == {$past(threshold_r), 2'h0}) else $error("threshold word not four times register");
  a_cal_reference: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
    front_end_r[1] |=> reference_calibration_select) else $error("calibration select not applied");
  a_coast_pause: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    (!front_end_r[2] && (pll_coasting || protect_interval)) |=> !dc_clamp_run && !black_level_servo_run)
    else $error("clamp ran while coasting");
  a_mid_override: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
    front_end_r[7] |=> midscale_shift == $past(front_end_r[6:4])) else $error("override midscale wrong");
  a_mid_mode: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
    (!front_end_r[7] && !ycbcr_mode) |=> midscale_shift == 3'h0) else $error("midscale ignored mode");
  a_dither_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
    !noise_r[0] |=> dither_offset == 4'h0) else $error("dither while disabled");
  a_dither_span: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
    noise_r[1] |=> !dither_offset[3]) else $error("dither exceeds eight LSBs");
  a_seed_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
    noise_r[4] |=> lfsr_r == front_end_control_pkg::LFSR_SEED) else $error("seed not restored");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |-> s_wr_done) else $error("write response missing");
  a_line_lock: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
    pll_locked |-> nco_inc_r >= front_end_control_pkg::NCO_MIN_INC && nco_inc_r <= front_end_control_pkg::NCO_MAX_INC)
    else $error("loop increment outside range");

endmodule // front_end_control_dither_regs

`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the front-end control and dither register block.
// Assumes the package is compiled first and the block is alone on its AXI4-Lite port.
`timescale 1ns/1ps
`default_nettype none

module tb;
  // Row layout: fe[15:8] ycbcr[7] coast[6] protect[5] cal[4] midscale[3:1] run[0].
  typedef logic [15:0] row_t;

  logic        aclk, aresetn;
  logic [31:0] awaddr, wdata, araddr, rdata, phase_result;
  logic [3:0]  wstrb, dither, mx;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, hsync, vsync, coast, prot, ycbcr;
  logic        cal, dc_run, servo_run, pixel_tick, sample_strobe, pll_locked, nz, same;
  logic [9:0]  threshold_word;
  logic [2:0]  midscale;
  logic [31:0] d;
  logic [3:0]  seq [2][6];
  int          fail_count, check_count;
  int          ticks, strobes, both;
  // At the slowest loop rate ten pixels take this many clocks.
  localparam int LINE_CLKS = 10 * front_end_control_pkg::CLK_MHZ / front_end_control_pkg::PIX_MIN_MHZ;
  row_t        rows [12] = '{16'h0001, 16'h00CA, 16'h0250, 16'h0441, 16'h0020, 16'h0421,
                             16'h708B, 16'hF00F, 16'h9083, 16'hA005, 16'hC009, 16'h0F51};

  front_end_control_dither_regs dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hsync_pulse(hsync), .vsync_pulse(vsync), .pll_coasting(coast), .protect_interval(prot),
    .ycbcr_mode(ycbcr), .phase_result(phase_result), .threshold_word(threshold_word),
    .reference_calibration_select(cal), .dc_clamp_run(dc_run), .black_level_servo_run(servo_run),
    .midscale_shift(midscale), .dither_offset(dither), .pixel_tick(pixel_tick),
    .sample_strobe(sample_strobe), .pll_locked(pll_locked));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("TB: errors %0d checks %0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] addr_of(input logic [7:0] idx);
    return {22'h000000, idx, 2'h0};
  endfunction

  // A missing answer is counted as a mismatch so a stuck slave cannot pass quietly.
  task automatic wait_high(ref logic sig);
    int n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (sig !== 1'b1 && n < 64);
    if (n >= 64)
    begin
      fail_count++;
      $display("Error at %0t: no answer from the register port", $time);
    end
  endtask

  task automatic axi_write(input logic [7:0] idx, input logic [31:0] v, output logic [1:0] resp);
    logic ad = 1'b0;
    logic wd = 1'b0;
    int   n  = 0;
    @(posedge aclk);
    awaddr  <= addr_of(idx);
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd) && n < 64)
    begin
      @(posedge aclk);
      n++;
      if (awready)
      begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wready)
      begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    wait_high(bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= addr_of(idx);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    wait_high(arready);
    arvalid <= 1'b0;
    wait_high(rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic pulse_h();
    @(posedge aclk);
    hsync <= 1'b1;
    @(posedge aclk);
    hsync <= 1'b0;
  endtask

  task automatic pulse_v();
    @(posedge aclk);
    vsync <= 1'b1;
    @(posedge aclk);
    vsync <= 1'b0;
  endtask

  // Lines are one clock longer than ten pixels, so each count window spans exactly ten.
  task automatic send_lines(input int n);
    repeat (n)
    begin
      pulse_h();
      repeat (LINE_CLKS - 1) @(posedge aclk);
    end
  endtask

  task automatic count_pulses(output int t, output int s, output int b);
    t = 0;
    s = 0;
    b = 0;
    repeat (LINE_CLKS)
    begin
      @(posedge aclk);
      if (pixel_tick)
        t++;
      if (sample_strobe)
        s++;
      if (pixel_tick && sample_strobe)
        b++;
    end
  endtask

  task automatic sample_dither(output logic [3:0] m, output logic any);
    m = 4'h0;
    any = 1'b0;
    repeat (200)
    begin
      @(posedge aclk);
      if (dither > m)
        m = dither;
      if (dither != 4'h0)
        any = 1'b1;
    end
  endtask

  // ---------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial
  begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    {hsync, vsync, coast, prot, ycbcr, aresetn} = '0;
    wstrb = 4'hF;
    phase_result = 32'h1234_5678;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    check(threshold_word, 32'h028);
    axi_read(front_end_control_pkg::IDX_THRESHOLD, d, r);
    check(d, front_end_control_pkg::RST_THRESHOLD);
    axi_read(front_end_control_pkg::IDX_FRONT_END, d, r);
    check(d, front_end_control_pkg::RST_FRONT_END);
    axi_read(front_end_control_pkg::IDX_NOISE, d, r);
    check(d, front_end_control_pkg::RST_NOISE);
    // No line has been seen yet, so the loop still runs at its slowest rate.
    axi_write(front_end_control_pkg::IDX_LINE_PIXELS, 32'h0000_000A, r);
    axi_write(front_end_control_pkg::IDX_PHASE_SEL, 32'h0000_0020, r);
    repeat (4) @(posedge aclk);
    count_pulses(ticks, strobes, both);
    check(ticks, 10);
    check(strobes, 10);
    check(both, 0);
    send_lines(6);
    check(pll_locked, 1'b0);
    send_lines(5);
    check(pll_locked, 1'b1);
    foreach (rows[i])
    begin
      ycbcr <= rows[i][7];
      coast <= rows[i][6];
      prot  <= rows[i][5];
      axi_write(front_end_control_pkg::IDX_FRONT_END, {24'h000000, rows[i][15:8]}, r);
      repeat (3) @(posedge aclk);
      check(cal, rows[i][4]);
      check(midscale, rows[i][3:1]);
      check(dc_run, rows[i][0]);
      check(servo_run, rows[i][0]);
      axi_read(front_end_control_pkg::IDX_FRONT_END, d, r);
      check(d, {24'h000000, rows[i][15:8] & front_end_control_pkg::FE_WMASK});
    end
    axi_write(front_end_control_pkg::IDX_THRESHOLD, 32'h0000_00FF, r);
    repeat (3) @(posedge aclk);
    check(threshold_word, 32'h3FC);
    axi_write(front_end_control_pkg::IDX_THRESHOLD, 32'h0000_0001, r);
    repeat (3) @(posedge aclk);
    check(threshold_word, 32'h004);
    // Read-only result bytes must ignore writes and mirror the engine result.
    for (int k = 0; k < 4; k++)
    begin
      axi_write(front_end_control_pkg::IDX_RESULT3 + 8'(k), 32'h0000_00FF, r);
      axi_read(front_end_control_pkg::IDX_RESULT3 + 8'(k), d, r);
      check(d, (phase_result >> (8 * (3 - k))) & 32'h0000_00FF);
    end
    axi_write(front_end_control_pkg::IDX_PHASE_SEL, 32'h0000_007F, r);
    axi_read(front_end_control_pkg::IDX_PHASE_SEL, d, r);
    check(d, 32'h0000_003F);
    axi_read(8'h70, d, r);
    check(d, 32'h0000_0000);
    check(r, 2'h2);
    axi_write(8'h70, 32'h0000_0001, r);
    check(r, 2'h2);
    axi_write(front_end_control_pkg::IDX_NOISE, 32'h0000_0003, r);
    sample_dither(mx, nz);
    check(mx <= 4'h7, 1'b1);
    check(nz, 1'b1);
    axi_write(front_end_control_pkg::IDX_NOISE, 32'h0000_0011, r);
    axi_write(front_end_control_pkg::IDX_NOISE, 32'h0000_0001, r);
    sample_dither(mx, nz);
    check(mx[3], 1'b1);
    axi_write(front_end_control_pkg::IDX_NOISE, 32'h0000_0000, r);
    repeat (3) @(posedge aclk);
    sample_dither(mx, nz);
    check(nz, 1'b0);
    // Line and field codes must hold the value while pixels, and for field codes lines, go by.
    for (int c = 1; c < 4; c++)
    begin
      axi_write(front_end_control_pkg::IDX_NOISE, 32'(8'h11 | (c << 2)), r);
      axi_write(front_end_control_pkg::IDX_NOISE, 32'(8'h01 | (c << 2)), r);
      repeat (3) @(posedge aclk);
      same = 1'b1;
      repeat (10)
      begin
        if (c > 1)
          pulse_h();
        else
          repeat (8) @(posedge aclk);
        if (dither !== front_end_control_pkg::LFSR_SEED[3:0])
          same = 1'b0;
      end
      check(same, 1'b1);
      if (c > 1)
        pulse_v();
      else
        pulse_h();
      repeat (2) @(posedge aclk);
      check(dither !== front_end_control_pkg::LFSR_SEED[3:0], 1'b1);
    end
    for (int p = 0; p < 2; p++)
    begin
      axi_write(front_end_control_pkg::IDX_NOISE, 32'h0000_0015, r);
      pulse_h();
      axi_write(front_end_control_pkg::IDX_NOISE, 32'h0000_0005, r);
      for (int k = 0; k < 6; k++)
      begin
        pulse_h();
        repeat (2) @(posedge aclk);
        seq[p][k] = dither;
      end
    end
    for (int k = 0; k < 6; k++)
      check(seq[1][k], seq[0][k]);
    report_and_stop();
  end
endmodule // tb

`default_nettype wire
